// [verilog/lsw_irq_pkg.sv]
// shared constants and carrier structs for the load switch irq block
package lsw_irq_pkg;

  // ***********************************
  // register offsets
  // ***********************************
  localparam logic [7:0] PRIMARY_FLAGS_OFF = 8'h01;
  localparam logic [7:0] SWITCH_FLAGS_OFF = 8'h02;
  localparam logic [7:0] IRQ_MASK_PRIMARY_OFF = 8'h03;

  // ***********************************
  // field positions
  // ***********************************
  localparam int PROG_VOLTAGE_BIT = 5;
  localparam int ADAPTER_CHANGE_BIT = 4;
  localparam int BUTTON_CHANGE_BIT = 3;
  localparam int OVERTEMP_WARN_BIT = 2;
  localparam int BACKUP_CELL_ACQ_BIT = 1;
  localparam int PROG_DONE_BIT = 0;
  localparam int SW_FAULT_LSB = 3;
  localparam int SW_LIMIT_LSB = 0;
  localparam int NUM_SWITCHES = 3;

  // ***********************************
  // reset values and field masks
  // ***********************************
  localparam logic [7:0] IRQ_MASK_PRIMARY_RST = 8'h00;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [7:0] WRITABLE_MASK_BITS = 8'h3f;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // per-switch status from the analog side
  typedef struct packed {
    logic [2:0] overtemp;    // index 0 = switch one
    logic sw2_undervolt;
    logic [2:0] limiting;
    logic [2:0] enabled;
  } switch_status_s;

  // first-group event sources
  typedef struct packed {
    logic prog_voltage_low;  // level
    logic adapter_change;    // pulse
    logic button_change;     // pulse
    logic overtemp_warn;     // level
    logic backup_cell_acq;   // pulse
    logic prog_done;         // pulse
  } primary_events_s;

  // whole block state
  typedef struct packed {
    logic [7:0] primary_event_flags;
    logic [7:0] switch_event_flags;
    logic [7:0] irq_mask_primary;
    logic [7:0] rdata;
    logic irq_out_n;
  } state_s;

endpackage

// [verilog/load_switch_irq_status_mask.sv]
// status flags, primary mask and active-low interrupt line
// Function
// - bit 5 set while switch three is thermally shut off, else zero.
// - bit 4 set while switch two is off by overtemp or low input.
// - bit 3 set while switch one is thermally shut off, else zero.
// - bits 2..0 set while switches three, two, one limit output current.
// - limit flag reads zero when its switch is off or not limiting.
// - primary mask resets to zero; bits 5..0 writable, bits 7..6 read-only.
// - unmasked event drives the active-low interrupt output low.
// - masked event has no effect on the interrupt output.
// - voltage mask gates signalling only; monitoring keeps running.
// - primary status register holds the six events whatever the mask holds.
module load_switch_irq_status_mask (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire lsw_irq_pkg::primary_events_s events,
  input wire lsw_irq_pkg::switch_status_s sw,
  output logic irq_out_n
);

  // ***********************************
  // decode
  // ***********************************
  function automatic logic hit(input logic [7:0] addr,
                               input logic [7:0] off);
    hit = (addr == off);
  endfunction

  lsw_irq_pkg::state_s st;
  lsw_irq_pkg::state_s next_st;
  logic [7:0] event_set;
  logic [7:0] live_switch;
  logic rd_primary;
  logic [7:0] next_pending;

  // ***********************************
  // switch flags follow live status
  // ***********************************
  genvar gi;
  generate
    for (gi = 0; gi < lsw_irq_pkg::NUM_SWITCHES; gi++) begin : g_sw
      // limit only counts while the switch is on
      assign live_switch[lsw_irq_pkg::SW_LIMIT_LSB + gi] =
        sw.limiting[gi] & sw.enabled[gi];
    end
  endgenerate
  assign live_switch[lsw_irq_pkg::SW_FAULT_LSB + 0] = sw.overtemp[0];
  assign live_switch[lsw_irq_pkg::SW_FAULT_LSB + 1] =
    sw.overtemp[1] | sw.sw2_undervolt;
  assign live_switch[lsw_irq_pkg::SW_FAULT_LSB + 2] = sw.overtemp[2];
  assign live_switch[7:6] = 2'h0;

  // ***********************************
  // primary event capture
  // ***********************************
  // the voltage monitor feeds the flag whatever the mask holds
  always_comb begin
    event_set = 8'h00;
    event_set[lsw_irq_pkg::PROG_VOLTAGE_BIT] = events.prog_voltage_low;
    event_set[lsw_irq_pkg::ADAPTER_CHANGE_BIT] = events.adapter_change;
    event_set[lsw_irq_pkg::BUTTON_CHANGE_BIT] = events.button_change;
    event_set[lsw_irq_pkg::OVERTEMP_WARN_BIT] = events.overtemp_warn;
    event_set[lsw_irq_pkg::BACKUP_CELL_ACQ_BIT] = events.backup_cell_acq;
    event_set[lsw_irq_pkg::PROG_DONE_BIT] = events.prog_done;
  end

  assign rd_primary = reg_rd_en &
    hit(reg_addr, lsw_irq_pkg::PRIMARY_FLAGS_OFF);

  // ***********************************
  // next state
  // ***********************************
  always_comb begin
    next_st = st;
    next_st.switch_event_flags = live_switch;
    // read clears, a same-cycle event still wins
    next_st.primary_event_flags =
      (rd_primary ? 8'h00 : st.primary_event_flags) | event_set;
    if (reg_wr_en && hit(reg_addr, lsw_irq_pkg::IRQ_MASK_PRIMARY_OFF)) begin
      next_st.irq_mask_primary =
        reg_wdata & lsw_irq_pkg::WRITABLE_MASK_BITS;
    end
    next_st.rdata = lsw_irq_pkg::UNMAPPED_READ;
    if (reg_rd_en) begin
      case (reg_addr)
        lsw_irq_pkg::PRIMARY_FLAGS_OFF: begin
          next_st.rdata = st.primary_event_flags;
        end
        lsw_irq_pkg::SWITCH_FLAGS_OFF: begin
          next_st.rdata = st.switch_event_flags;
        end
        lsw_irq_pkg::IRQ_MASK_PRIMARY_OFF: begin
          next_st.rdata = st.irq_mask_primary;
        end
        default: begin
          next_st.rdata = lsw_irq_pkg::UNMAPPED_READ;
        end
      endcase
    end
    // from next values so the pin lines up with the flags it reports
    next_pending = next_st.primary_event_flags &
      ~next_st.irq_mask_primary;
    next_st.irq_out_n = ~(|next_pending);
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st.primary_event_flags <= lsw_irq_pkg::FLAGS_RST;
      st.switch_event_flags <= lsw_irq_pkg::FLAGS_RST;
      st.irq_mask_primary <= lsw_irq_pkg::IRQ_MASK_PRIMARY_RST;
      st.rdata <= lsw_irq_pkg::UNMAPPED_READ;
      st.irq_out_n <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata = st.rdata;
  assign irq_out_n = st.irq_out_n;

  // ***********************************
  // checks
  // ***********************************
  AST_SW3_FAULT: assert property (@(posedge sys_clk) disable iff (rst)
    sw.overtemp[2] |=> st.switch_event_flags[5])
    else $error("switch three fault flag not set");
  AST_SW2_FAULT: assert property (@(posedge sys_clk) disable iff (rst)
    (sw.overtemp[1] || sw.sw2_undervolt) |=> st.switch_event_flags[4])
    else $error("switch two fault flag not set");
  AST_SW1_FAULT: assert property (@(posedge sys_clk) disable iff (rst)
    !sw.overtemp[0] |=> !st.switch_event_flags[3])
    else $error("switch one fault flag set without cause");
  AST_SW3_LIMIT: assert property (@(posedge sys_clk) disable iff (rst)
    (sw.limiting[2] && sw.enabled[2]) |=> st.switch_event_flags[2])
    else $error("switch three limit flag not set");
  AST_LIMIT_OFF: assert property (@(posedge sys_clk) disable iff (rst)
    !sw.enabled[1] |=> !st.switch_event_flags[1])
    else $error("limit flag set while switch off");
  AST_MASK_RO: assert property (@(posedge sys_clk) disable iff (rst)
    st.irq_mask_primary[7:6] == 2'h0)
    else $error("read-only mask bits changed");
  AST_UNMASKED_IRQ: assert property (@(posedge sys_clk)
    disable iff (rst)
    (events.adapter_change && !next_st.irq_mask_primary[4]) |=> !irq_out_n)
    else $error("unmasked event did not pull interrupt low");
  AST_MASKED_QUIET: assert property (@(posedge sys_clk)
    disable iff (rst)
    (st.irq_mask_primary[5:0] == 6'h3f) |-> irq_out_n)
    else $error("masked events drove interrupt");
  AST_VMON_MASKED: assert property (@(posedge sys_clk) disable iff (rst)
    (events.prog_voltage_low && st.irq_mask_primary[5])
      |=> st.primary_event_flags[5])
    else $error("voltage monitor stopped under mask");
  AST_SET_WINS: assert property (@(posedge sys_clk) disable iff (rst)
    (events.button_change && rd_primary) |=> st.primary_event_flags[3])
    else $error("event lost on clearing read");
  AST_RELEASE: assert property (@(posedge sys_clk) disable iff (rst)
    (rd_primary && event_set == 8'h00) |=> irq_out_n)
    else $error("interrupt held with no pending flag");

  // ***********************************
  // register port and pin checks
  // ***********************************
  // every output is registered, so read data is looked at one edge later; the pin is checked in the same cycle as the flags
  AST_SW3_CLEAR: assert property (@(posedge sys_clk) disable iff (rst)
    !sw.overtemp[2] |=> !st.switch_event_flags[5])
    else $error("switch three fault flag set without cause");
  AST_SW2_CLEAR: assert property (@(posedge sys_clk) disable iff (rst)
    !(sw.overtemp[1] || sw.sw2_undervolt) |=> !st.switch_event_flags[4])
    else $error("switch two fault flag set without cause");
  AST_SW1_SET: assert property (@(posedge sys_clk) disable iff (rst)
    sw.overtemp[0] |=> st.switch_event_flags[3])
    else $error("switch one fault flag not set");
  AST_SW2_LIMIT: assert property (@(posedge sys_clk) disable iff (rst)
    (sw.limiting[1] && sw.enabled[1]) |=> st.switch_event_flags[1])
    else $error("switch two limit flag not set");
  AST_SW1_LIMIT: assert property (@(posedge sys_clk) disable iff (rst)
    (sw.limiting[0] && sw.enabled[0]) |=> st.switch_event_flags[0])
    else $error("switch one limit flag not set");
  AST_LIMIT_IDLE: assert property (@(posedge sys_clk) disable iff (rst)
    !sw.limiting[2] |=> !st.switch_event_flags[2])
    else $error("limit flag set while not limiting");
  AST_LIMIT_OFF1: assert property (@(posedge sys_clk) disable iff (rst)
    !sw.enabled[0] |=> !st.switch_event_flags[0])
    else $error("switch one limit flag set while off");
  AST_SW_RSVD: assert property (@(posedge sys_clk) disable iff (rst)
    st.switch_event_flags[7:6] == 2'h0)
    else $error("reserved switch flag bits set");
  AST_PRIM_RSVD: assert property (@(posedge sys_clk) disable iff (rst)
    st.primary_event_flags[7:6] == 2'h0)
    else $error("reserved primary flag bits set");
  AST_MASK_WRITE: assert property (@(posedge sys_clk) disable iff (rst)
    (reg_wr_en && hit(reg_addr, lsw_irq_pkg::IRQ_MASK_PRIMARY_OFF))
      |=> st.irq_mask_primary ==
      ($past(reg_wdata) & lsw_irq_pkg::WRITABLE_MASK_BITS))
    else $error("mask write did not land");
  AST_MASK_HOLD: assert property (@(posedge sys_clk) disable iff (rst)
    !(reg_wr_en && hit(reg_addr, lsw_irq_pkg::IRQ_MASK_PRIMARY_OFF))
      |=> $stable(st.irq_mask_primary))
    else $error("mask changed without a write");
  AST_PRIM_READ: assert property (@(posedge sys_clk) disable iff (rst)
    rd_primary |=> reg_rdata == $past(st.primary_event_flags))
    else $error("primary flag read returned wrong data");
  AST_SW_READ: assert property (@(posedge sys_clk) disable iff (rst)
    (reg_rd_en && hit(reg_addr, lsw_irq_pkg::SWITCH_FLAGS_OFF))
      |=> reg_rdata == $past(st.switch_event_flags))
    else $error("switch flag read returned wrong data");
  AST_MASK_READ: assert property (@(posedge sys_clk) disable iff (rst)
    (reg_rd_en && hit(reg_addr, lsw_irq_pkg::IRQ_MASK_PRIMARY_OFF))
      |=> reg_rdata == $past(st.irq_mask_primary))
    else $error("mask read returned wrong data");
  AST_RDATA_IDLE: assert property (@(posedge sys_clk) disable iff (rst)
    !reg_rd_en |=> reg_rdata == 8'h00)
    else $error("read data stood without a read");
  AST_STICKY: assert property (@(posedge sys_clk) disable iff (rst)
    (st.primary_event_flags[0] && !rd_primary)
      |=> st.primary_event_flags[0])
    else $error("primary flag dropped without a read");
  AST_EVENT_SET: assert property (@(posedge sys_clk) disable iff (rst)
    events.prog_done |=> st.primary_event_flags[0])
    else $error("programming done flag not set");
  AST_VMON_FLAG: assert property (@(posedge sys_clk) disable iff (rst)
    events.prog_voltage_low |=> st.primary_event_flags[5])
    else $error("voltage flag not set");
  AST_IRQ_LOW: assert property (@(posedge sys_clk) disable iff (rst)
    |(st.primary_event_flags & ~st.irq_mask_primary) |-> !irq_out_n)
    else $error("interrupt released with a pending flag");
  AST_IRQ_HIGH: assert property (@(posedge sys_clk) disable iff (rst)
    !(|(st.primary_event_flags & ~st.irq_mask_primary)) |-> irq_out_n)
    else $error("interrupt low with nothing pending");

endmodule

// [verification/host_model.sv]
// host side model: register port master that senses the interrupt line
module host_model (
  input wire logic sys_clk,
  input wire logic [7:0] reg_rdata,
  input wire logic irq_out_n,
  output logic [7:0] reg_addr,
  output logic reg_wr_en,
  output logic reg_rd_en,
  output logic [7:0] reg_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    reg_addr = 8'h00;
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_wdata = 8'h00;
  end
  // wait for the next falling edge, then one access, so no strobe moves twice at one edge
  task automatic access(input logic wr, input logic [7:0] a,
                        input logic [7:0] d, output logic [7:0] q);
    @(negedge sys_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr_en = wr;
    reg_rd_en = !wr;
    @(negedge sys_clk);
    q = reg_rdata;
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    // released data must not keep showing the last value
    reg_wdata = ~d;
    reg_addr = ~a;
  endtask
  task automatic sense(output logic l);
    l = irq_out_n;
  endtask
endmodule

// [verification/load_switch_irq_status_mask_bench.sv]
// self-checking bench for the load switch irq status and mask block
module load_switch_irq_status_mask_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, q, e;
  logic reg_wr_en, reg_rd_en, irq_out_n, l;
  lsw_irq_pkg::primary_events_s events = '0;
  lsw_irq_pkg::switch_status_s sw = '0;
  int n_errors = 0;
  int comparisons = 0;
  int cycles = 0;
  int mask, pf, b;
  load_switch_irq_status_mask dut (.sys_clk(sys_clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .events(events),
    .sw(sw), .irq_out_n(irq_out_n));
  host_model host (.sys_clk(sys_clk), .reg_rdata(reg_rdata),
    .irq_out_n(irq_out_n), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_wdata(reg_wdata));
  initial forever #12.5 sys_clk = ~sys_clk;
  // about 155 cycles are needed; the ceiling of 5000 leaves wide margin
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      finish_test();
    end
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic chk_irq();
    host.sense(l);
    chk({7'h00, l}, {7'h00, (pf & ~mask & 'h3f) == 0});
  endtask
  task automatic finish_test();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // ***********
  // main sequence
  // ***********
  initial begin
    void'($urandom(49));
    repeat (20) @(negedge sys_clk);
    rst = 1'b0;
    mask = 0;
    pf = 0;
    host.access(1'b0, lsw_irq_pkg::IRQ_MASK_PRIMARY_OFF, 8'h00, q);
    chk(q, 8'h00);
    chk_irq();
    host.access(1'b1, lsw_irq_pkg::IRQ_MASK_PRIMARY_OFF, 8'hff, q);
    host.access(1'b0, lsw_irq_pkg::IRQ_MASK_PRIMARY_OFF, 8'h00, q);
    chk(q, 8'h3f);
    host.access(1'b1, lsw_irq_pkg::PRIMARY_FLAGS_OFF, 8'hff, q);
    host.access(1'b0, 8'h7f, 8'h00, q);
    chk(q, 8'h00);
    host.access(1'b0, lsw_irq_pkg::PRIMARY_FLAGS_OFF, 8'h00, q);
    chk(q, 8'h00);
    repeat (24) begin
      sw = lsw_irq_pkg::switch_status_s'(10'($urandom));
      e = {2'b00, sw.overtemp[2], sw.overtemp[1] | sw.sw2_undervolt,
           sw.overtemp[0], sw.limiting & sw.enabled};
      host.access(1'b0, lsw_irq_pkg::SWITCH_FLAGS_OFF, 8'h00, q);
      chk(q, e);
    end
    // each event once unmasked, once masked, other mask bits random
    for (int i = 0; i < 12; i++) begin
      b = 1 << (i % 6);
      mask = ($urandom & 'h3f & ~b) | ((i >= 6) ? b : 0);
      host.access(1'b1, lsw_irq_pkg::IRQ_MASK_PRIMARY_OFF, 8'(mask), q);
      events = lsw_irq_pkg::primary_events_s'(6'(b));
      @(negedge sys_clk);
      events = '0;
      pf = b;
      chk_irq();
      host.access(1'b0, lsw_irq_pkg::PRIMARY_FLAGS_OFF, 8'h00, q);
      chk(q, 8'(pf));
      pf = 0;
      chk_irq();
    end
    // an event in the clearing read's cycle survives the clear
    mask = 0;
    host.access(1'b1, lsw_irq_pkg::IRQ_MASK_PRIMARY_OFF, 8'h00, q);
    fork
      host.access(1'b0, lsw_irq_pkg::PRIMARY_FLAGS_OFF, 8'h00, q);
      begin
        @(negedge sys_clk);
        events = lsw_irq_pkg::primary_events_s'(6'h08);
        @(negedge sys_clk);
        events = '0;
      end
    join
    chk(q, 8'h00);
    pf = 'h08;
    chk_irq();
    host.access(1'b0, lsw_irq_pkg::PRIMARY_FLAGS_OFF, 8'h00, q);
    chk(q, 8'(pf));
    pf = 0;
    chk_irq();
    // a reset in mid-run drops a pending flag and the mask
    host.access(1'b1, lsw_irq_pkg::IRQ_MASK_PRIMARY_OFF, 8'h15, q);
    events = lsw_irq_pkg::primary_events_s'(6'h02);
    @(negedge sys_clk);
    events = '0;
    mask = 'h15;
    pf = 'h02;
    chk_irq();
    rst = 1'b1;
    repeat (2) @(negedge sys_clk);
    rst = 1'b0;
    mask = 0;
    pf = 0;
    chk_irq();
    host.access(1'b0, lsw_irq_pkg::IRQ_MASK_PRIMARY_OFF, 8'h00, q);
    chk(q, 8'h00);
    host.access(1'b0, lsw_irq_pkg::PRIMARY_FLAGS_OFF, 8'h00, q);
    chk(q, 8'h00);
    finish_test();
  end
endmodule
